// File: usb_interface_machine.v
`timescale 1ns/100ps
`default_nettype none
`include "usb_interface_machine_regs.vh"
module usb_interface_machine #(
    parameter FLAG_W = 7,
    parameter FRAME_W = 11
) (
    input wire CORE_CLK_I,
    input wire RST_B_I,
    input wire CE_I,
    input wire REG_WR_I,
    input wire REG_RD_I,
    input wire [7:0] REG_ADDR_I,
    input wire [31:0] REG_WDATA_I,
    output reg [31:0] REG_RDATA_O,
    input wire [7:0] RX_DATA_I,
    input wire RX_VALID_I,
    input wire RX_ACTIVE_I,
    input wire RX_ERROR_I,
    input wire [1:0] LINE_STATE_I,
    input wire B_SESSION_VALID_I,
    input wire ID_GROUND_I,
    input wire HOST_DISCONNECT_I,
    input wire BUS_POWER_VALID_I,
    input wire SESSION_VALID_I,
    input wire SESSION_END_I,
    input wire DIFF_RX_I,
    input wire MINUS_LINE_RX_I,
    input wire PLUS_LINE_RX_I,
    output wire SERIAL_TX_SE0_O,
    output wire SERIAL_TX_BIT_O,
    output wire SERIAL_TX_ENABLE_B_O,
    output wire FULL_LOW_SPEED_SERIAL_O,
    output reg FLAG_PORT0_O,
    output reg FLAG_PORT1_O,
    output reg FLAG_PORT2_O,
    output reg FLAG_PORT3_O,
    output reg [4:0] RX_ENDPOINT_O,
    output reg RX_ENDPOINT_VALID_O
);
    localparam ST_PID = 2'h0;
    localparam ST_TOKEN = 2'h1;
    localparam ST_DATA = 2'h2;
    localparam ST_SKIP = 2'h3;

    reg [5:0] otg_status_r;
    reg [2:0] rx_lines_r;
    reg [3:0] serial_ctl_r;
    reg [6:0] dev_addr_r;
    reg [FLAG_W-1:0] hold_sel_r;
    reg [31:0] port_masks_r;
    reg [FRAME_W-1:0] frame_r;
    reg [FRAME_W-1:0] frame_nxt;
    reg [3:0] pid_r;
    reg [3:0] ep_r;
    reg ep_valid_r;
    reg [15:0] ep_tag_r;
    reg [31:0] otg_mask_r;
    reg [8:0] power_sig_r;
    reg [1:0] state_r;
    reg [1:0] state_nxt;
    reg [1:0] count_r;
    reg [3:0] tok_pid_r;
    reg [7:0] tok_lo_r;
    reg [7:0] tok_hi_r;
    reg rx_active_d_r;
    reg token_ok_r;
    reg crc_fail_r;
    reg [31:0] rdata_nxt;

    wire [FLAG_W-1:0] flags;
    wire [FLAG_W-1:0] flag_events;
    wire soft_rst;
    wire wr_flags;
    wire packet_start;
    wire packet_end;
    wire byte_in;
    wire pid_good;
    wire is_token;
    wire is_data;
    wire crc16_ok;
    wire crc5_ok;
    wire addr_match;
    wire tok_is_sof;
    wire token_good;
    wire [3:0] tok_ep;

    function wr_hit;
        input [7:0] ofs;
        begin
            wr_hit = REG_WR_I & (REG_ADDR_I == ofs);
        end
    endfunction

    function any_selected;
        input [7:0] mask;
        input [FLAG_W-1:0] f;
        begin
            any_selected = |(mask[FLAG_W-1:0] & f);
        end
    endfunction

    function [4:0] crc5_token;
        input [15:0] d;
        integer k;
        reg [4:0] c;
        begin
            c = `CRC5_INIT;
            for (k = 0; k < 16; k = k + 1)
                c = {c[3:0], 1'b0} ^ ((c[4] ^ d[k]) ? `CRC5_POLY : 5'h00);
            crc5_token = c;
        end
    endfunction

    // A write of any data to the reset offset restarts the machine.
    assign soft_rst = CE_I & wr_hit(`OFS_MACHINE_RESET);
    assign wr_flags = wr_hit(`OFS_LINE_EVENT_FLAGS);
    assign packet_start = RX_ACTIVE_I & ~rx_active_d_r;
    assign packet_end = ~RX_ACTIVE_I & rx_active_d_r;
    assign byte_in = RX_ACTIVE_I & RX_VALID_I;
    assign pid_good = (RX_DATA_I[7:4] == ~RX_DATA_I[3:0]);
    assign is_token = (RX_DATA_I[3:0] == `PID_OUT) || (RX_DATA_I[3:0] == `PID_IN)
                      || (RX_DATA_I[3:0] == `PID_SOF) || (RX_DATA_I[3:0] == `PID_SETUP);
    assign is_data = (RX_DATA_I[1:0] == `PID_DATA_LOW2);
    assign crc5_ok = (crc5_token({tok_hi_r, tok_lo_r}) == `CRC5_RESIDUE);
    assign tok_is_sof = (tok_pid_r == `PID_SOF);
    assign tok_ep = {tok_hi_r[2:0], tok_lo_r[7]};
    // Frame tokens carry no address, so only addressed tokens are filtered.
    assign addr_match = tok_is_sof | (tok_lo_r[6:0] == dev_addr_r);
    assign token_good = packet_end & (state_r == ST_TOKEN) & (count_r == 2'h2)
                        & crc5_ok & addr_match;

    assign SERIAL_TX_SE0_O = serial_ctl_r[`SERIAL_TX_SE0_BIT];
    assign SERIAL_TX_BIT_O = serial_ctl_r[`SERIAL_TX_DATA_BIT];
    assign SERIAL_TX_ENABLE_B_O = serial_ctl_r[`SERIAL_TX_EN_LOW_BIT];
    assign FULL_LOW_SPEED_SERIAL_O = serial_ctl_r[`SERIAL_FSLS_BIT];

    assign flag_events[`FLAG_TOKEN_BIT] = token_ok_r;
    assign flag_events[`FLAG_SE0_BIT] = (LINE_STATE_I == `LINE_SE0);
    assign flag_events[`FLAG_K_BIT] = (LINE_STATE_I == `LINE_K);
    assign flag_events[`FLAG_J_BIT] = (LINE_STATE_I == `LINE_J);
    assign flag_events[`FLAG_CRC16_BIT] = crc_fail_r;
    assign flag_events[`FLAG_RX_ACTIVE_BIT] = RX_ACTIVE_I;
    assign flag_events[`FLAG_RX_ERROR_BIT] = RX_ERROR_I;

    flag_hold #(
        .WIDTH(FLAG_W),
        .LEVEL_BITS(`FLAG_LEVEL_BITS)
    ) u_flags (
        .clk_i(CORE_CLK_I),
        .rst_b_i(RST_B_I),
        .ce_i(CE_I),
        .soft_rst_i(soft_rst),
        .event_i(flag_events),
        .hold_i(hold_sel_r),
        .packet_start_i(packet_start),
        .wr_i(wr_flags),
        .wdata_i(REG_WDATA_I[FLAG_W-1:0]),
        .flags_o(flags)
    );

    crc16_check u_crc16 (
        .clk_i(CORE_CLK_I),
        .rst_b_i(RST_B_I),
        .ce_i(CE_I),
        .init_i(packet_start),
        .byte_vld_i(byte_in & (state_r == ST_DATA)),
        .byte_i(RX_DATA_I),
        .crc_ok_o(crc16_ok)
    );

    always @*
    begin
        state_nxt = state_r;
        if (packet_end | packet_start)
            state_nxt = ST_PID;
        else if (byte_in)
        begin
            case (state_r)
                ST_PID:
                begin
                    if (!pid_good)
                        state_nxt = ST_SKIP;
                    else if (is_token)
                        state_nxt = ST_TOKEN;
                    else if (is_data)
                        state_nxt = ST_DATA;
                    else
                        state_nxt = ST_SKIP;
                end
                ST_TOKEN: state_nxt = ST_TOKEN;
                ST_DATA: state_nxt = ST_DATA;
                default: state_nxt = ST_SKIP;
            endcase
        end
    end

    // Receive parser: PID byte, then token bytes or data bytes.
    always @(posedge CORE_CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            state_r <= ST_PID;
            count_r <= 2'h0;
            tok_pid_r <= 4'h0;
            tok_lo_r <= 8'h00;
            tok_hi_r <= 8'h00;
            rx_active_d_r <= 1'b0;
            token_ok_r <= 1'b0;
            crc_fail_r <= 1'b0;
            pid_r <= 4'h0;
        end
        else if (CE_I)
        begin
            if (soft_rst)
            begin
                state_r <= ST_PID;
                count_r <= 2'h0;
                tok_pid_r <= 4'h0;
                tok_lo_r <= 8'h00;
                tok_hi_r <= 8'h00;
                rx_active_d_r <= 1'b0;
                token_ok_r <= 1'b0;
                crc_fail_r <= 1'b0;
                pid_r <= 4'h0;
            end
            else
            begin
                rx_active_d_r <= RX_ACTIVE_I;
                state_r <= state_nxt;
                token_ok_r <= token_good;
                // A data packet with fewer than three bytes after its PID also counts as failed.
                crc_fail_r <= packet_end & (state_r == ST_DATA)
                              & ((count_r != 2'h3) | ~crc16_ok);
                if (packet_start)
                    count_r <= 2'h0;
                else if (byte_in & (state_r != ST_PID) & (count_r != 2'h3))
                    count_r <= count_r + 2'h1;
                if (byte_in & (state_r == ST_PID))
                begin
                    pid_r <= RX_DATA_I[3:0];
                    tok_pid_r <= RX_DATA_I[3:0];
                end
                if (byte_in & (state_r == ST_TOKEN) & (count_r == 2'h0))
                    tok_lo_r <= RX_DATA_I;
                if (byte_in & (state_r == ST_TOKEN) & (count_r == 2'h1))
                    tok_hi_r <= RX_DATA_I;
            end
        end
    end

    always @*
    begin
        frame_nxt = frame_r;
        if (wr_hit(`OFS_FRAME_COUNTER))
            frame_nxt = REG_WDATA_I[FRAME_W-1:0];
        // The bus decode loads the new frame over a software write in the same cycle.
        if (token_good & tok_is_sof)
            frame_nxt = {tok_hi_r[2:0], tok_lo_r};
    end

    // Endpoint capture and frame count.
    always @(posedge CORE_CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            frame_r <= {FRAME_W{1'b0}};
            ep_r <= 4'h0;
            ep_valid_r <= 1'b0;
            RX_ENDPOINT_O <= 5'h00;
            RX_ENDPOINT_VALID_O <= 1'b0;
        end
        else if (CE_I)
        begin
            if (soft_rst)
            begin
                frame_r <= {FRAME_W{1'b0}};
                ep_r <= 4'h0;
                ep_valid_r <= 1'b0;
                RX_ENDPOINT_O <= 5'h00;
                RX_ENDPOINT_VALID_O <= 1'b0;
            end
            else
            begin
                frame_r <= frame_nxt;
                RX_ENDPOINT_VALID_O <= 1'b0;
                if (token_good & ~tok_is_sof)
                begin
                    ep_r <= tok_ep;
                    ep_valid_r <= 1'b1;
                    RX_ENDPOINT_O <= {ep_tag_r[tok_ep], tok_ep};
                    RX_ENDPOINT_VALID_O <= 1'b1;
                end
            end
        end
    end

    // Software registers and the line status mirrors.
    always @(posedge CORE_CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            otg_status_r <= 6'h00;
            rx_lines_r <= 3'h0;
            serial_ctl_r <= `SERIAL_CONTROL_RESET;
            dev_addr_r <= 7'h00;
            hold_sel_r <= {FLAG_W{1'b0}};
            port_masks_r <= 32'h00000000;
            ep_tag_r <= 16'h0000;
            otg_mask_r <= 32'h00000000;
            power_sig_r <= 9'h000;
        end
        else if (CE_I)
        begin
            otg_status_r <= {B_SESSION_VALID_I, ID_GROUND_I, HOST_DISCONNECT_I,
                             BUS_POWER_VALID_I, SESSION_VALID_I, SESSION_END_I};
            rx_lines_r <= {DIFF_RX_I, MINUS_LINE_RX_I, PLUS_LINE_RX_I};
            if (wr_hit(`OFS_SERIAL_LINE_CONTROL))
                serial_ctl_r <= REG_WDATA_I[3:0];
            // The transceiver controls stay put across a machine reset.
            if (soft_rst)
            begin
                dev_addr_r <= 7'h00;
                hold_sel_r <= {FLAG_W{1'b0}};
                port_masks_r <= 32'h00000000;
                ep_tag_r <= 16'h0000;
                otg_mask_r <= 32'h00000000;
                power_sig_r <= 9'h000;
            end
            else
            begin
                if (wr_hit(`OFS_DEVICE_ADDRESS))
                    dev_addr_r <= REG_WDATA_I[6:0];
                if (wr_hit(`OFS_FLAG_STICKINESS))
                    hold_sel_r <= REG_WDATA_I[FLAG_W-1:0];
                if (wr_hit(`OFS_FLAG_PORT_MASKS))
                    port_masks_r <= REG_WDATA_I;
                if (wr_hit(`OFS_ENDPOINT_TAG_SELECT))
                    ep_tag_r <= REG_WDATA_I[15:0];
                if (wr_hit(`OFS_OTG_FLAG_MASK))
                    otg_mask_r <= REG_WDATA_I;
                if (wr_hit(`OFS_POWER_SIGNAL))
                    power_sig_r <= REG_WDATA_I[8:0];
            end
        end
    end

    // Each port goes high while any flag its mask selects is high.
    always @(posedge CORE_CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            FLAG_PORT0_O <= 1'b0;
            FLAG_PORT1_O <= 1'b0;
            FLAG_PORT2_O <= 1'b0;
            FLAG_PORT3_O <= 1'b0;
        end
        else if (CE_I)
        begin
            FLAG_PORT0_O <= any_selected(port_masks_r[7:0], flags);
            FLAG_PORT1_O <= any_selected(port_masks_r[15:8], flags);
            FLAG_PORT2_O <= any_selected(port_masks_r[23:16], flags);
            FLAG_PORT3_O <= any_selected(port_masks_r[31:24], flags);
        end
    end

    always @*
    begin
        rdata_nxt = 32'h00000000;
        case (REG_ADDR_I)
            `OFS_DEVICE_ADDRESS: rdata_nxt[6:0] = dev_addr_r;
            `OFS_OTG_STATUS: rdata_nxt[5:0] = otg_status_r;
            `OFS_SERIAL_LINE_CONTROL: rdata_nxt[6:0] = {rx_lines_r, serial_ctl_r};
            `OFS_LINE_EVENT_FLAGS: rdata_nxt[FLAG_W-1:0] = flags;
            `OFS_FLAG_STICKINESS: rdata_nxt[FLAG_W-1:0] = hold_sel_r;
            `OFS_FLAG_PORT_MASKS: rdata_nxt = port_masks_r;
            `OFS_FRAME_COUNTER: rdata_nxt[FRAME_W-1:0] = frame_r;
            `OFS_LAST_PACKET_ID: rdata_nxt[3:0] = pid_r;
            `OFS_LAST_ENDPOINT: rdata_nxt[4:0] = {ep_valid_r, ep_r};
            `OFS_ENDPOINT_TAG_SELECT: rdata_nxt[15:0] = ep_tag_r;
            `OFS_OTG_FLAG_MASK: rdata_nxt = otg_mask_r;
            `OFS_POWER_SIGNAL: rdata_nxt[8:0] = power_sig_r;
            default: rdata_nxt = 32'h00000000;
        endcase
    end

    // Read data is held until the next read so the processor may sample late.
    always @(posedge CORE_CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
            REG_RDATA_O <= 32'h00000000;
        else if (CE_I & REG_RD_I)
            REG_RDATA_O <= rdata_nxt;
    end
endmodule // usb_interface_machine
`default_nettype wire

// File: usb_interface_machine_regs.vh
// Operation
// - Mirror six on-the-go status inputs, reset zero.
// - Expose differential, minus, plus receive bits.
// - Drive serial SE0 and data from bits.
// - Active-low transmit enable bit resets to one.
// - Bit zero selects full/low-speed serial mode.
// - Flag six marks a good matching token.
// - Flags five, four, three show SE0, K, J.
// - Flag two marks data CRC16 failure.
// - Flags one, zero follow receive active, error.
// - Non-sticky flags six, two clear on next packet; others follow level.
// - Sticky flags hold until written one.
// - Four masks OR selected flags onto ports.
// - Eleven-bit frame counter, readable and writable.
// - Capture last packet identifier, reset zero.
// - Keep last endpoint with valid bit.
// - Tagged endpoints presented ORed with 0x10.
// - Accept only tokens matching programmed address, except SOF.
// - Any reset-register write restarts machine state.
`ifndef USB_INTERFACE_MACHINE_REGS_VH
`define USB_INTERFACE_MACHINE_REGS_VH
`define OFS_MACHINE_RESET 8'h00
`define OFS_DEVICE_ADDRESS 8'h08
`define OFS_OTG_STATUS 8'h14
`define OFS_SERIAL_LINE_CONTROL 8'h18
`define OFS_LINE_EVENT_FLAGS 8'h1c
`define OFS_FLAG_STICKINESS 8'h20
`define OFS_FLAG_PORT_MASKS 8'h24
`define OFS_FRAME_COUNTER 8'h28
`define OFS_LAST_PACKET_ID 8'h2c
`define OFS_LAST_ENDPOINT 8'h30
`define OFS_ENDPOINT_TAG_SELECT 8'h34
`define OFS_OTG_FLAG_MASK 8'h38
`define OFS_POWER_SIGNAL 8'h3c
`define SERIAL_DIFF_RX_BIT 6
`define SERIAL_MINUS_RX_BIT 5
`define SERIAL_PLUS_RX_BIT 4
`define SERIAL_TX_SE0_BIT 3
`define SERIAL_TX_DATA_BIT 2
`define SERIAL_TX_EN_LOW_BIT 1
`define SERIAL_FSLS_BIT 0
`define SERIAL_CONTROL_RESET 4'h2
`define FLAG_TOKEN_BIT 6
`define FLAG_SE0_BIT 5
`define FLAG_K_BIT 4
`define FLAG_J_BIT 3
`define FLAG_CRC16_BIT 2
`define FLAG_RX_ACTIVE_BIT 1
`define FLAG_RX_ERROR_BIT 0
`define FLAG_LEVEL_BITS 7'h3b
`define ENDPOINT_VALID_BIT 4
`define POWER_VALID_BIT 8
`define LINE_SE0 2'h0
`define LINE_J 2'h1
`define LINE_K 2'h2
`define PID_OUT 4'h1
`define PID_IN 4'h9
`define PID_SOF 4'h5
`define PID_SETUP 4'hd
`define PID_DATA_LOW2 2'h3
`define CRC5_INIT 5'h1f
`define CRC5_POLY 5'h05
`define CRC5_RESIDUE 5'h0c
`define CRC16_INIT 16'hffff
`define CRC16_POLY 16'h8005
`define CRC16_RESIDUE 16'h800d
`endif

// File: flag_hold.v
`timescale 1ns/100ps
`default_nettype none
module flag_hold #(
    parameter WIDTH = 7,
    parameter [WIDTH-1:0] LEVEL_BITS = 7'h3b
) (
    input wire clk_i,
    input wire rst_b_i,
    input wire ce_i,
    input wire soft_rst_i,
    input wire [WIDTH-1:0] event_i,
    input wire [WIDTH-1:0] hold_i,
    input wire packet_start_i,
    input wire wr_i,
    input wire [WIDTH-1:0] wdata_i,
    output reg [WIDTH-1:0] flags_o
);
    reg [WIDTH-1:0] flags_nxt;
    integer i;
    always @*
    begin
        flags_nxt = flags_o;
        for (i = 0; i < WIDTH; i = i + 1)
        begin
            if (hold_i[i])
                // A new event wins over a software clear in the same cycle.
                flags_nxt[i] = event_i[i] | (flags_o[i] & ~(wr_i & wdata_i[i]));
            else if (LEVEL_BITS[i])
                flags_nxt[i] = event_i[i];
            else if (wr_i)
                flags_nxt[i] = event_i[i] | wdata_i[i];
            else
                flags_nxt[i] = event_i[i] | (flags_o[i] & ~packet_start_i);
        end
    end
    always @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            flags_o <= {WIDTH{1'b0}};
        else if (ce_i)
        begin
            if (soft_rst_i)
                flags_o <= {WIDTH{1'b0}};
            else
                flags_o <= flags_nxt;
        end
    end
endmodule // flag_hold
`default_nettype wire

// File: crc16_check.v
`timescale 1ns/100ps
`default_nettype none
`include "usb_interface_machine_regs.vh"
module crc16_check (
    input wire clk_i,
    input wire rst_b_i,
    input wire ce_i,
    input wire init_i,
    input wire byte_vld_i,
    input wire [7:0] byte_i,
    output wire crc_ok_o
);
    reg [15:0] crc_r;
    // Bits enter least significant first, as they travel on the wire.
    function [15:0] crc16_byte;
        input [15:0] crc;
        input [7:0] d;
        integer k;
        reg [15:0] c;
        begin
            c = crc;
            for (k = 0; k < 8; k = k + 1)
                c = {c[14:0], 1'b0} ^ ((c[15] ^ d[k]) ? `CRC16_POLY : 16'h0000);
            crc16_byte = c;
        end
    endfunction
    always @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            crc_r <= `CRC16_INIT;
        else if (ce_i)
        begin
            if (init_i)
                crc_r <= `CRC16_INIT;
            else if (byte_vld_i)
                crc_r <= crc16_byte(crc_r, byte_i);
        end
    end
    assign crc_ok_o = (crc_r == `CRC16_RESIDUE);
endmodule // crc16_check
`default_nettype wire

// File: usb_interface_machine_chk.sv
`timescale 1ns/100ps
`default_nettype none
module usb_interface_machine_chk (
    input wire logic CORE_CLK_I,
    input wire logic RST_B_I,
    input wire logic CE_I,
    input wire logic REG_WR_I,
    input wire logic REG_RD_I,
    input wire logic [7:0] REG_ADDR_I,
    input wire logic [31:0] REG_WDATA_I,
    input wire logic [31:0] REG_RDATA_O,
    input wire logic B_SESSION_VALID_I,
    input wire logic ID_GROUND_I,
    input wire logic HOST_DISCONNECT_I,
    input wire logic BUS_POWER_VALID_I,
    input wire logic SESSION_VALID_I,
    input wire logic SESSION_END_I,
    input wire logic DIFF_RX_I,
    input wire logic MINUS_LINE_RX_I,
    input wire logic PLUS_LINE_RX_I,
    input wire logic SERIAL_TX_SE0_O,
    input wire logic SERIAL_TX_BIT_O,
    input wire logic SERIAL_TX_ENABLE_B_O,
    input wire logic FULL_LOW_SPEED_SERIAL_O,
    input wire logic FLAG_PORT0_O,
    input wire logic FLAG_PORT1_O,
    input wire logic FLAG_PORT2_O,
    input wire logic FLAG_PORT3_O
);
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (!RST_B_I);
    wire wr18 = CE_I && REG_WR_I && REG_ADDR_I == 8'h18;
    wire wr00 = CE_I && REG_WR_I && REG_ADDR_I == 8'h00;
    wire rd = CE_I && REG_RD_I;
    wire [5:0] otg = {B_SESSION_VALID_I, ID_GROUND_I, HOST_DISCONNECT_I, BUS_POWER_VALID_I, SESSION_VALID_I, SESSION_END_I};
    wire [2:0] rxl = {DIFF_RX_I, MINUS_LINE_RX_I, PLUS_LINE_RX_I};
    wire [3:0] txo = {SERIAL_TX_SE0_O, SERIAL_TX_BIT_O, SERIAL_TX_ENABLE_B_O, FULL_LOW_SPEED_SERIAL_O};
    wire ports = FLAG_PORT0_O || FLAG_PORT1_O || FLAG_PORT2_O || FLAG_PORT3_O;
    // Masks clear at the reset edge, but the ports lag the flags by one more cycle.
    sequence s_soft_rst;
        wr00 ##1 CE_I;
    endsequence
    property p_tx_lines;
        wr18 |=> {SERIAL_TX_SE0_O, SERIAL_TX_BIT_O} == $past(REG_WDATA_I[3:2]);
    endproperty
    property p_tx_enable;
        wr18 |=> SERIAL_TX_ENABLE_B_O == $past(REG_WDATA_I[1]);
    endproperty
    property p_fsls;
        wr18 |=> FULL_LOW_SPEED_SERIAL_O == $past(REG_WDATA_I[0]);
    endproperty
    property p_otg_read;
        rd && REG_ADDR_I == 8'h14 && $stable(otg) |=> REG_RDATA_O == {26'h0, $past(otg)};
    endproperty
    property p_serial_read;
        rd && REG_ADDR_I == 8'h18 && $stable(rxl) |=> REG_RDATA_O == {25'h0, $past(rxl), $past(txo)};
    endproperty
    property p_unmapped;
        rd && (REG_ADDR_I == 8'h04 || REG_ADDR_I == 8'h0c) |=> REG_RDATA_O == 32'h0;
    endproperty
    property p_soft_ports;
        s_soft_rst |=> !ports;
    endproperty
    property p_soft_keep;
        wr00 |=> $stable(txo);
    endproperty
    a_tx_lines: assert property (p_tx_lines) else $error("tx lines wrong");
    a_tx_enable: assert property (p_tx_enable) else $error("tx enable wrong");
    a_fsls: assert property (p_fsls) else $error("serial mode wrong");
    a_otg_read: assert property (p_otg_read) else $error("otg status wrong");
    a_serial_read: assert property (p_serial_read) else $error("serial status wrong");
    a_unmapped: assert property (p_unmapped) else $error("unmapped not zero");
    a_soft_ports: assert property (p_soft_ports) else $error("ports after reset");
    a_soft_keep: assert property (p_soft_keep) else $error("serial disturbed");
endmodule // usb_interface_machine_chk
`default_nettype wire

// File: usb_utmi_phy_model.sv
`timescale 1ns/100ps
`default_nettype none
module usb_utmi_phy_model (
    input wire logic clk_i,
    output logic [7:0] rx_data_o,
    output logic rx_valid_o,
    output logic rx_active_o,
    output logic rx_error_o,
    output logic [1:0] line_state_o,
    output logic [5:0] otg_o,
    output logic [2:0] rxl_o
);
    initial
    begin
        {rx_data_o, rx_valid_o, rx_active_o, rx_error_o, otg_o, rxl_o} = '0;
        line_state_o = 2'h1;
    end
    task automatic send(input logic [7:0] b [3]);
        @(posedge clk_i);
        rx_active_o <= 1'b1;
        for (int i = 0; i < 3; i++)
        begin
            @(posedge clk_i);
            rx_valid_o <= 1'b1;
            rx_data_o <= b[i];
        end
        @(posedge clk_i);
        rx_valid_o <= 1'b0;
        rx_active_o <= 1'b0;
        // Stale data is inverted so a design that samples it late cannot pass by luck.
        rx_data_o <= ~b[2];
    endtask
    task automatic lines(input logic [1:0] l, input logic e, input logic [5:0] o, input logic [2:0] r);
        @(posedge clk_i);
        line_state_o <= l;
        rx_error_o <= e;
        otg_o <= o;
        rxl_o <= r;
    endtask
endmodule // usb_utmi_phy_model
`default_nettype wire

// File: usb_interface_machine_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module usb_interface_machine_tb_top;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic wr = 1'b0;
    logic rd = 1'b0, ce = 1'b1;
    logic [7:0] addr = 8'h0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] d;
    logic [31:0] v;
    wire logic [31:0] rdata;
    wire logic [7:0] rx_data;
    wire logic rx_valid, rx_active, rx_error, se0, txb, txen_b, fsls, p0, p1, p2, p3, ep_vld;
    wire logic [1:0] ls;
    wire logic [5:0] otg;
    wire logic [2:0] rxl;
    wire logic [4:0] ep;
    int num_errors = 0;
    int total_checks = 0;
    logic [7:0] ofs [12] = '{8'h04, 8'h08, 8'h14, 8'h18, 8'h20, 8'h24, 8'h28, 8'h2c, 8'h30, 8'h34, 8'h38, 8'h3c};
    logic [31:0] msk [12] = '{0, 32'h7f, 0, 32'hf, 32'h7f, '1, 32'h7ff, 0, 0, 32'hffff, '1, 32'h1ff};
    logic [7:0] pids [4] = '{8'ha5, 8'h69, 8'he1, 8'h2d};
    always #5 clk = ~clk;
    usb_interface_machine u_dut (.CORE_CLK_I(clk), .RST_B_I(rst_b), .CE_I(ce), .REG_WR_I(wr), .REG_RD_I(rd),
        .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_RDATA_O(rdata), .RX_DATA_I(rx_data), .RX_VALID_I(rx_valid),
        .RX_ACTIVE_I(rx_active), .RX_ERROR_I(rx_error), .LINE_STATE_I(ls), .B_SESSION_VALID_I(otg[5]),
        .ID_GROUND_I(otg[4]), .HOST_DISCONNECT_I(otg[3]), .BUS_POWER_VALID_I(otg[2]), .SESSION_VALID_I(otg[1]),
        .SESSION_END_I(otg[0]), .DIFF_RX_I(rxl[2]), .MINUS_LINE_RX_I(rxl[1]), .PLUS_LINE_RX_I(rxl[0]),
        .SERIAL_TX_SE0_O(se0), .SERIAL_TX_BIT_O(txb), .SERIAL_TX_ENABLE_B_O(txen_b), .FULL_LOW_SPEED_SERIAL_O(fsls),
        .FLAG_PORT0_O(p0), .FLAG_PORT1_O(p1), .FLAG_PORT2_O(p2), .FLAG_PORT3_O(p3), .RX_ENDPOINT_O(ep),
        .RX_ENDPOINT_VALID_O(ep_vld));
    usb_utmi_phy_model u_phy (.clk_i(clk), .rx_data_o(rx_data), .rx_valid_o(rx_valid), .rx_active_o(rx_active),
        .rx_error_o(rx_error), .line_state_o(ls), .otg_o(otg), .rxl_o(rxl));
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic write(input logic [7:0] a, input logic [31:0] x);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= x;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask
    task automatic read(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        check(rdata & m, e);
    endtask
    function automatic logic [4:0] crc5(input logic [10:0] x);
        logic [4:0] c;
        logic [4:0] r;
        c = 5'h1f;
        for (int i = 0; i < 11; i++)
            c = {c[3:0], 1'b0} ^ ((x[i] ^ c[4]) ? 5'h05 : 5'h00);
        for (int i = 0; i < 5; i++)
            r[i] = ~c[4 - i];
        return r;
    endfunction
    task automatic pkt(input logic [7:0] pid, input logic [10:0] x, input logic bad, input logic want);
        logic hit;
        hit = 1'b0;
        u_phy.send('{pid, x[7:0], {crc5(x) ^ {4'h0, bad}, x[10:8]}});
        for (int i = 0; i < 8; i++)
        begin
            @(posedge clk);
            #1;
            hit = hit | ep_vld;
        end
        check({31'h0, hit}, {31'h0, want});
    endtask
    task automatic conclude;
        $display("checks %0d, errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial
    begin
        v = $urandom(19992);
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        for (int i = 0; i < 12; i++)
            read(ofs[i], '1, (ofs[i] == 8'h18) ? 32'h2 : 32'h0);
        for (int i = 0; i < 12; i++)
        begin
            d = $urandom;
            write(ofs[i], d);
            read(ofs[i], '1, d & msk[i]);
        end
        for (int i = 0; i < 6; i++)
        begin
            d = $urandom;
            u_phy.lines({1'b0, d[8]}, 1'b0, d[15:10], d[18:16]);
            write(8'h18, d);
            check({28'h0, se0, txb, txen_b, fsls}, {28'h0, d[3:0]});
            read(8'h18, '1, {25'h0, d[18:16], d[3:0]});
            read(8'h14, '1, {26'h0, d[15:10]});
        end
        v = {28'h0, se0, txb, txen_b, fsls};
        write(8'h00, $urandom);
        check({28'h0, se0, txb, txen_b, fsls}, v);
        ce <= 1'b0;
        write(8'h24, $urandom);
        ce <= 1'b1;
        read(8'h24, '1, 32'h0);
        write(8'h24, 32'h30201008);
        for (int l = 0; l < 3; l++)
        begin
            d = $urandom;
            u_phy.lines(2'(l), d[0], 6'h0, 3'h0);
            repeat (4) @(posedge clk);
            #1;
            v = {26'h0, l == 0, l == 2, l == 1, 2'h0, d[0]};
            check({28'h0, p3, p2, p1, p0}, {28'h0, v[5] | v[4], v[5], v[4], v[3]});
            read(8'h1c, 32'h39, v);
        end
        write(8'h34, 32'h2);
        for (int i = 1; i < 4; i++)
        begin
            pkt(pids[i], {4'(i), 7'h0}, 1'b0, 1'b1);
            check({27'h0, ep}, {27'h0, i == 1, 4'(i)});
            read(8'h2c, '1, {28'h0, pids[i][3:0]});
            read(8'h30, '1, 32'h10 | i);
            read(8'h1c, 32'h40, 32'h40);
        end
        pkt(8'h69, 11'h080, 1'b1, 1'b0);
        read(8'h1c, 32'h40, 32'h0);
        write(8'h08, 32'h5);
        pkt(8'h69, 11'h080, 1'b0, 1'b0);
        pkt(8'h69, 11'h085, 1'b0, 1'b1);
        d = $urandom;
        pkt(8'ha5, d[10:0], 1'b0, 1'b0);
        read(8'h28, '1, d & 32'h7ff);
        write(8'h20, 32'h40);
        pkt(8'h69, 11'h085, 1'b0, 1'b1);
        pkt(8'hc3, 11'h7ff, 1'b0, 1'b0);
        read(8'h1c, 32'h44, 32'h44);
        write(8'h1c, 32'h40);
        read(8'h1c, 32'h40, 32'h0);
        conclude;
    end
endmodule // usb_interface_machine_tb_top
bind usb_interface_machine usb_interface_machine_chk u_chk (.*);
`default_nettype wire
